// ### sbst_pkg.sv
// sbst_pkg: shared constants and types for the boundary-scan test port.
// assumes: included before every other file of the block.
package sbst_pkg;
  // ==========================================================
  // instruction codes, three bits wide
  localparam int IR_W = 3;
  localparam logic [2:0] INS_EXTEST = 3'h0;
  localparam logic [2:0] INS_IDCODE = 3'h1;
  localparam logic [2:0] INS_SAMPLEZ = 3'h2;
  localparam logic [2:0] INS_PRIV3 = 3'h3;
  localparam logic [2:0] INS_SAMPLE = 3'h4;
  localparam logic [2:0] INS_PRIV5 = 3'h5;
  localparam logic [2:0] INS_PRIV6 = 3'h6;
  localparam logic [2:0] INS_BYPASS = 3'h7;
  // capture pattern loaded into the instruction shifter
  localparam logic [2:0] IR_CAPTURE = 3'h1;
  localparam logic [2:0] IR_RESET = INS_IDCODE;
  // identification code width; the value itself is a top parameter
  localparam int ID_W = 32;
  // reset-state entry: consecutive high mode-select edges
  localparam int RST_EDGES = 5;
  // ==========================================================
  // controller states
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR,
    ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
    ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } sbst_state_t;
  // synchronised pin samples travelling together
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } sbst_pins_t;
endpackage : sbst_pkg

// ### sbst_fifo.sv
// sbst_fifo: small valid/ready FIFO carrying shifted-out bits to the pin.
// assumes: single clock, same domain as both sides.
`timescale 1ns/1ps
module sbst_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic flush_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  // ==========================================================
  // storage and pointers
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [AW:0] cnt_ff, nxt_cnt;
  logic push, pop;

  assign in_ready_o = cnt_ff != (AW+1)'(DEPTH);
  assign out_valid_o = cnt_ff != '0;
  assign out_data_o = mem_ff[rd_ff];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // pointer arithmetic; flush drops everything queued
  always_comb begin
    nxt_wr = wr_ff;
    nxt_rd = rd_ff;
    nxt_cnt = cnt_ff;
    if (flush_i) begin
      nxt_wr = '0;
      nxt_rd = '0;
      nxt_cnt = '0;
    end else begin
      if (push) nxt_wr = (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
      if (pop) nxt_rd = (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
      nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // registers only
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else if (en_i) begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
      if (push && !flush_i) mem_ff[wr_ff] <= in_data_i;
    end
  end
endmodule : sbst_fifo

// ### sbst_tap.sv
// sbst_tap: boundary-scan test access port of the memory device.
// assumes: test pins arrive unsynchronised; clk_i is much faster than the
// test clock; boundary cells are supplied by the memory ring as vectors.
// Behaviour
// RULE1: act on test-clock rise, output on fall
// RULE2: mode-select sampled on rise, pulled high
// RULE3: serial input pulled up, enters register MSB
// RULE4: instruction chooses the serial-path register
// RULE5: only one register in the path
// RULE6: serial output is LSB, changes on fall
// RULE7: output driver enabled only while shifting
// RULE8: five high mode-select edges reach reset
// RULE9: test reset leaves memory operation alone
// RULE10: power-up reset, serial output high impedance
// RULE11: board disables port by holding clock low
// RULE12: follow the standard boundary-scan controller
// RULE13: three-bit instruction, identify default, capture 01
// RULE14: single bypass bit, cleared on capture
// RULE15: identification code captured and shifted
// RULE16: instruction takes effect only after update
// RULE17: sixteen-state controller stepped by mode-select
`timescale 1ns/1ps
module sbst_tap import sbst_pkg::*; #(
  parameter int BSR_W = 110,
  parameter logic [31:0] ID_CODE = 32'h0000_0001 // arbitrary value
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic [BSR_W-1:0] ring_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  output logic [BSR_W-1:0] preload_o,
  output logic [IR_W-1:0] instr_o,
  output logic test_reset_o
);
  // ==========================================================
  // pin synchronisers; first stage feeds only the second
  sbst_pins_t meta_ff, sync_ff, prev_ff;
  logic rise, fall;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_ff <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1}; // pull-ups read high, see RULE2 see RULE3
      sync_ff <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
      prev_ff <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
    end else if (en_i) begin
      meta_ff <= '{tck: tck_i, tms: tms_i, tdi: tdi_i};
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end
  // edges of the test clock; a clock held low never steps anything
  assign rise = en_i && sync_ff.tck && !prev_ff.tck; // see RULE1 see RULE11
  assign fall = en_i && !sync_ff.tck && prev_ff.tck; // see RULE1

  // ==========================================================
  // controller
  sbst_state_t st_ff, nxt_st;
  always_comb begin
    nxt_st = st_ff;
    if (rise) begin
      // standard sixteen-state walk, see RULE12 see RULE17 see RULE2
      case (st_ff)
        ST_RESET: nxt_st = sync_ff.tms ? ST_RESET : ST_IDLE;
        ST_IDLE: nxt_st = sync_ff.tms ? ST_SEL_DR : ST_IDLE;
        ST_SEL_DR: nxt_st = sync_ff.tms ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: nxt_st = sync_ff.tms ? ST_EX1_DR : ST_SH_DR;
        ST_SH_DR: nxt_st = sync_ff.tms ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR: nxt_st = sync_ff.tms ? ST_UPD_DR : ST_PAU_DR;
        ST_PAU_DR: nxt_st = sync_ff.tms ? ST_EX2_DR : ST_PAU_DR;
        ST_EX2_DR: nxt_st = sync_ff.tms ? ST_UPD_DR : ST_SH_DR;
        ST_UPD_DR: nxt_st = sync_ff.tms ? ST_SEL_DR : ST_IDLE;
        ST_SEL_IR: nxt_st = sync_ff.tms ? ST_RESET : ST_CAP_IR;
        ST_CAP_IR: nxt_st = sync_ff.tms ? ST_EX1_IR : ST_SH_IR;
        ST_SH_IR: nxt_st = sync_ff.tms ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR: nxt_st = sync_ff.tms ? ST_UPD_IR : ST_PAU_IR;
        ST_PAU_IR: nxt_st = sync_ff.tms ? ST_EX2_IR : ST_PAU_IR;
        ST_EX2_IR: nxt_st = sync_ff.tms ? ST_UPD_IR : ST_SH_IR;
        ST_UPD_IR: nxt_st = sync_ff.tms ? ST_SEL_DR : ST_IDLE;
        default: nxt_st = ST_RESET;
      endcase
    end
  end

  // ==========================================================
  // scan registers, updated on test-clock rise only; the instruction is also forced to identify while in reset
  logic [IR_W-1:0] irs_ff, nxt_irs, ir_ff, nxt_ir;
  logic [ID_W-1:0] ids_ff, nxt_ids;
  logic [BSR_W-1:0] bsr_ff, nxt_bsr, pre_ff, nxt_pre;
  logic byp_ff, nxt_byp;
  logic sel_bit; // the one bit presented to the output path
  always_comb begin
    nxt_irs = irs_ff;
    nxt_ir = ir_ff;
    nxt_ids = ids_ff;
    nxt_bsr = bsr_ff;
    nxt_pre = pre_ff;
    nxt_byp = byp_ff;
    if (rise) begin
      case (st_ff)
        ST_RESET: nxt_ir = IR_RESET; // identify after reset, see RULE13
        ST_CAP_IR: nxt_irs = IR_CAPTURE; // see RULE13
        ST_SH_IR: nxt_irs = {sync_ff.tdi, irs_ff[IR_W-1:1]}; // MSB in, see RULE3
        ST_UPD_IR: nxt_ir = irs_ff; // only here does it take effect, see RULE16
        ST_CAP_DR: begin
          if (ir_ff == INS_IDCODE) nxt_ids = ID_CODE; // see RULE15
          else if (ir_ff == INS_EXTEST || ir_ff == INS_SAMPLE || ir_ff == INS_SAMPLEZ)
            nxt_bsr = ring_i;
          else nxt_byp = 1'b0; // bypass and private codes share it, see RULE14
        end
        ST_SH_DR: begin
          // only the selected register moves, see RULE4 see RULE5
          if (ir_ff == INS_IDCODE) nxt_ids = {sync_ff.tdi, ids_ff[ID_W-1:1]}; // see RULE15
          else if (ir_ff == INS_EXTEST || ir_ff == INS_SAMPLE || ir_ff == INS_SAMPLEZ)
            nxt_bsr = {sync_ff.tdi, bsr_ff[BSR_W-1:1]}; // see RULE3
          else nxt_byp = sync_ff.tdi; // see RULE14
        end
        ST_UPD_DR: begin
          if (ir_ff == INS_EXTEST || ir_ff == INS_SAMPLE) nxt_pre = bsr_ff;
        end
        default: nxt_ir = ir_ff;
      endcase
    end
    // identify is held for as long as the controller rests in reset
    if (st_ff == ST_RESET) nxt_ir = IR_RESET; // see RULE13
    // output path multiplexer: least significant bit of one register
    if (st_ff == ST_SH_IR) sel_bit = irs_ff[0]; // see RULE6 see RULE5
    else if (ir_ff == INS_IDCODE) sel_bit = ids_ff[0];
    else if (ir_ff == INS_EXTEST || ir_ff == INS_SAMPLE || ir_ff == INS_SAMPLEZ)
      sel_bit = bsr_ff[0];
    else sel_bit = byp_ff;
  end

  // ==========================================================
  // falling-edge launch stage into the FIFO; drives only while shifting
  logic shifting, q_valid, q_ready, q_data, f_ready, nxt_tdo, nxt_oe;
  logic tdo_ff, oe_ff;
  logic test_rst_ff, nxt_test_rst; // registered so the output comes from a flop
  assign shifting = st_ff == ST_SH_DR || st_ff == ST_SH_IR;
  // the FIFO keeps ordering if the pin side is ever held back
  sbst_fifo #(.WIDTH(1), .DEPTH(4)) u_outq (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .en_i(en_i),
    .flush_i(st_ff == ST_RESET),
    .in_data_i(sel_bit),
    .in_valid_i(fall && shifting),
    .in_ready_o(f_ready),
    .out_data_o(q_data),
    .out_valid_o(q_valid),
    .out_ready_i(q_ready)
  );
  assign q_ready = 1'b1;
  always_comb begin
    nxt_tdo = tdo_ff;
    nxt_oe = oe_ff;
    if (q_valid) nxt_tdo = q_data; // changes two clocks after the fall, see RULE6
    if (fall) nxt_oe = shifting && f_ready; // see RULE7
    // follows the next state so it moves on the same edge as the controller
    nxt_test_rst = nxt_st == ST_RESET; // see RULE9
  end

  // registers only; reset is the power-up test reset, see RULE10
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff <= ST_RESET;
      irs_ff <= '0;
      ir_ff <= IR_RESET;
      ids_ff <= '0;
      bsr_ff <= '0;
      pre_ff <= '0;
      byp_ff <= 1'b0;
      tdo_ff <= 1'b0;
      oe_ff <= 1'b0;
      test_rst_ff <= 1'b1;
    end else if (en_i) begin
      st_ff <= nxt_st;
      irs_ff <= nxt_irs;
      ir_ff <= nxt_ir;
      ids_ff <= nxt_ids;
      bsr_ff <= nxt_bsr;
      pre_ff <= nxt_pre;
      byp_ff <= nxt_byp;
      tdo_ff <= nxt_tdo;
      oe_ff <= nxt_oe;
      test_rst_ff <= nxt_test_rst;
    end
  end
  assign tdo_o = tdo_ff;
  assign tdo_oe_o = oe_ff;
  assign preload_o = pre_ff;
  assign instr_o = ir_ff;
  // memory side only observes; nothing here gates its operation, see RULE9
  assign test_reset_o = test_rst_ff;

  // ==========================================================
  // assertions
  localparam logic [2:0] HI_MAX = 3'(RST_EDGES);
  logic [2:0] hi_cnt_ff; // high mode-select rises in a row, saturating
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) hi_cnt_ff <= '0;
    else if (rise && !sync_ff.tms) hi_cnt_ff <= '0;
    else if (rise && hi_cnt_ff != HI_MAX) hi_cnt_ff <= hi_cnt_ff + 3'h1;
  end
  sequence fall_in_shift_s;
    fall && shifting;
  endsequence
  five_high_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // see RULE8
    (hi_cnt_ff == HI_MAX) |-> st_ff == ST_RESET) else $error("no reset after five high edges");
  oe_idle_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // see RULE7
    fall && !shifting |=> !oe_ff) else $error("output driven outside shift");
  oe_shift_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // see RULE7
    fall_in_shift_s |=> oe_ff) else $error("output not driven while shifting");
  tdo_fall_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // see RULE6
    fall_in_shift_s ##1 1'b1 |=> tdo_ff == $past(sel_bit, 2)) else $error("wrong output bit");
  st_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // see RULE1
    !rise |=> $stable(st_ff)) else $error("state moved without rise");
  ir_reset_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // see RULE13
    rise && st_ff == ST_RESET |=> ir_ff == INS_IDCODE) else $error("instr not identify");
  ir_cap_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // see RULE13
    rise && st_ff == ST_CAP_IR |=> irs_ff[1:0] == 2'h1) else $error("bad capture pattern");
  id_cap_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // see RULE15
    rise && st_ff == ST_CAP_DR && ir_ff == INS_IDCODE |=> ids_ff == ID_CODE)
    else $error("id not captured");
  ir_stable_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // see RULE16
    st_ff != ST_UPD_IR && st_ff != ST_RESET |=> $stable(ir_ff)) else $error("instr changed early");
endmodule : sbst_tap

// ### sbst_ctl_model.sv
// sbst_ctl_model: board test controller driving the test port pins.
// assumes: the test clock stands low between frames, lines pulled high.
`timescale 1ns/1ps
module sbst_ctl_model (
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i,
  input wire logic tdo_oe_i
);
  logic last; // last level seen on the serial output
  // ====
  // idle pins: clock held low, released lines at their pull-up level
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
    last = 1'b0;
  end
  // one test clock period of 48 ns, 24 high and 24 low; the output is sampled
  // just before the fall, though the port's synchroniser and queue already move
  // it shortly before the next rise; lines keep their level until the next step,
  // so no line is written twice in one instant
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #23 tck_o = 1'b1;
    #23;
    last = tdo_oe_i ? tdo_i : ~last; // an undriven pin shows no stale value
    tdo = last;
    #1 tck_o = 1'b0;
    #1;
  endtask : step
endmodule : sbst_ctl_model

// ### sbst_tap_tb_top.sv
// sbst_tap_tb_top: self-checking bench for the boundary-scan test port.
// assumes: sbst_pkg, sbst_fifo, sbst_tap and sbst_ctl_model compiled first.
`timescale 1ns/1ps
module sbst_tap_tb_top import sbst_pkg::*;;
  localparam int BSR_N = 8; // short ring keeps scans quick
  localparam logic [31:0] ID_VAL = 32'h1234_5678; // arbitrary value
  localparam int CEIL = 20000; // cycles; the run needs about 2150
  logic clk = 1'b0, nrst = 1'b0, en = 1'b1;
  logic tck, tms, tdi, tdo, tdo_oe, test_rst, b;
  logic [BSR_N-1:0] ring = 8'ha5, preload;
  logic [IR_W-1:0] instr, pre_instr;
  logic [31:0] d;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  // ====
  // clock and instances
  always #2.5 clk = ~clk;
  sbst_ctl_model u_ctl (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo),
    .tdo_oe_i(tdo_oe));
  sbst_tap #(.BSR_W(BSR_N), .ID_CODE(ID_VAL)) DUT (.clk_i(clk), .nrst_i(nrst),
    .en_i(en), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .ring_i(ring), .tdo_o(tdo),
    .tdo_oe_o(tdo_oe), .preload_o(preload), .instr_o(instr), .test_reset_o(test_rst));
  // ====
  // reporting
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one scan from idle back to idle; ir picks the instruction path
  task automatic scan(input logic ir, input logic [31:0] din, input int n,
    output logic [31:0] dout);
    dout = '0;
    u_ctl.step(1'b1, 1'b1, b);
    if (ir) u_ctl.step(1'b1, 1'b1, b);
    u_ctl.step(1'b0, 1'b1, b); // capture
    u_ctl.step(1'b0, 1'b1, b); // shift
    for (int i = 0; i < n; i++) begin
      u_ctl.step(i == n - 1, din[i], b); // last bit also leaves shifting
      dout[i] = b;
    end
    pre_instr = instr;
    u_ctl.step(1'b1, 1'b1, b);
    u_ctl.step(1'b0, 1'b1, b);
    check(tdo_oe, 1'b0);
  endtask : scan
  // ====
  // scenarios
  task automatic t_powerup;
    check(test_rst, 1'b1);
    check(tdo_oe, 1'b0);
    check(instr, IR_RESET);
    u_ctl.step(1'b0, 1'b1, b);
    check(test_rst, 1'b0);
    $display("test powerup done");
  endtask : t_powerup
  // every code: load it, then scan the register it selects
  task automatic t_codes;
    logic [IR_W-1:0] p;
    for (int c = 0; c < 8; c++) begin
      p = instr;
      scan(1'b1, c, IR_W, d);
      check(d, IR_CAPTURE);
      check(pre_instr, p);
      check(instr, c);
      if (c == 3 || c >= 5) begin
        scan(1'b0, 32'h0000_00b5, 8, d);
        check(d, 32'h0000_006a);
      end else if (c == 1) begin
        scan(1'b0, 32'h0f0f_3c3c, 32, d);
        check(d, ID_VAL);
      end else begin
        scan(1'b0, 32'h0000_003c, BSR_N, d);
        check(d, ring);
        if (c != 2) check(preload, 32'h0000_003c);
      end
    end
    $display("test codes done");
  endtask : t_codes
  // four high edges from shifting must not reach reset, the fifth must
  task automatic t_tms_reset;
    u_ctl.step(1'b1, 1'b1, b);
    u_ctl.step(1'b0, 1'b1, b);
    u_ctl.step(1'b0, 1'b1, b);
    repeat (4) u_ctl.step(1'b1, 1'b1, b);
    check(test_rst, 1'b0);
    u_ctl.step(1'b1, 1'b1, b);
    check(test_rst, 1'b1);
    check(instr, INS_IDCODE);
    check(tdo_oe, 1'b0);
    $display("test tms reset done");
  endtask : t_tms_reset
  // output queue through the port: shift, pause, resume, bits stay in order
  task automatic t_outq;
    logic [3:0] got;
    got = '0;
    u_ctl.step(1'b0, 1'b1, b); // leave reset
    check(instr, INS_IDCODE);
    u_ctl.step(1'b1, 1'b1, b);
    u_ctl.step(1'b0, 1'b1, b); // capture
    u_ctl.step(1'b0, 1'b1, b); // shift, bit 0 launched
    u_ctl.step(1'b1, 1'b0, got[0]); // leave for exit-1
    u_ctl.step(1'b0, 1'b0, b); // pause
    check(tdo_oe, 1'b0);
    u_ctl.step(1'b1, 1'b0, b); // exit-2
    u_ctl.step(1'b0, 1'b0, b); // back to shift, bit 1 launched
    u_ctl.step(1'b0, 1'b0, got[1]);
    check(tdo_oe, 1'b1);
    u_ctl.step(1'b0, 1'b0, got[2]);
    u_ctl.step(1'b1, 1'b0, got[3]);
    u_ctl.step(1'b1, 1'b1, b);
    u_ctl.step(1'b0, 1'b1, b);
    check(got, ID_VAL[3:0]);
    check(test_rst, 1'b0);
    $display("test outq done");
  endtask : t_outq
  // ====
  // main sequence and hang guard
  initial begin
    repeat (10) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (4) @(posedge clk);
    t_powerup();
    t_codes();
    t_tms_reset();
    t_outq();
    print_verdict();
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == CEIL) begin
      error_cnt++;
      print_verdict();
    end
  end
endmodule : sbst_tap_tb_top
